// ==== verilog/sct_pkg.sv ====
// package for the serial character transmitter: register map, field positions, frame sizes
// assumes a 32-bit apb slave with word-aligned registers
package sct_pkg;
  // register byte offsets
  localparam logic [7:0] SCT_STATUS_OFF = 8'h00;
  localparam logic [7:0] SCT_DATA_OFF   = 8'h04;
  localparam logic [7:0] SCT_CTRL1_OFF  = 8'h08;
  localparam logic [7:0] SCT_CTRL2_OFF  = 8'h0C;
  localparam logic [7:0] SCT_IRQST_OFF  = 8'h10;
  localparam logic [7:0] SCT_IRQMSK_OFF = 8'h14;
  // status fields
  localparam int SCT_ST_TXE  = 7;
  localparam int SCT_ST_TC   = 6;
  localparam int SCT_ST_BUSY = 0;
  // control 1 fields
  localparam int SCT_C1_NINTH = 6;
  localparam int SCT_C1_WLEN  = 4;
  // control 2 fields
  localparam int SCT_C2_TXE_IE = 7;
  localparam int SCT_C2_TC_IE  = 6;
  localparam int SCT_C2_TEN    = 3;
  // sticky interrupt status / mask fields
  localparam int SCT_IRQ_TXE = 0;
  localparam int SCT_IRQ_TC  = 1;
  localparam int SCT_IRQ_W   = 2;
  // frame shape
  localparam int SCT_DATA8   = 8;
  localparam int SCT_DATA9   = 9;
  localparam int SCT_PRE8    = 10;
  localparam int SCT_PRE9    = 11;
  localparam int SCT_CNT_W   = 4;
  localparam logic [31:0] SCT_STATUS_RST = 32'h0000_00C0;
  typedef enum logic [1:0] {SCT_IDLE, SCT_PREAMBLE, SCT_FRAME} sct_state_t;
endpackage

// ==== verilog/sct_apb_slave.sv ====
// apb slave front end: decodes address and produces one-cycle read and write strobes
// assumes the master follows apb setup/access phases; always zero wait state
`timescale 1ns/100ps
module sct_apb_slave (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  // decoded
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       acc_addr,
  output logic             unmapped
);
  import sct_pkg::*;
  always_comb begin
    wr_stb   = psel && penable && pwrite;
    rd_stb   = psel && penable && !pwrite;
    acc_addr = paddr;
    unmapped = !(paddr == SCT_STATUS_OFF || paddr == SCT_DATA_OFF ||
                 paddr == SCT_CTRL1_OFF  || paddr == SCT_CTRL2_OFF ||
                 paddr == SCT_IRQST_OFF  || paddr == SCT_IRQMSK_OFF);
  end
endmodule

// ==== verilog/sct_top.sv ====
// serial character transmitter: apb registers, holding buffer, shifter, flags, interrupt
// assumes a baud tick pulse of one pclk cycle per bit period from an outside generator
//
// Overview of operation
// - words are 8 or 9 data bits, chosen by the word length bit.
// - in 9-bit mode the ninth bit comes from control register 1.
// - data bits leave the line least significant bit first.
// - data register writes land in a holding buffer unless the transmitter is enabled and idle.
// - enabling the transmitter sends 10 or 11 idle ones first.
// - buffer-empty clears only after a status access then a data write.
// - buffer-empty sets when the buffer moves into the shifter.
// - buffer-empty requests an interrupt when its enable bit is set.
// - a write during shifting waits in the buffer until the frame ends.
// - a write while enabled and idle loads the shifter directly; buffer-empty stays set.
// - transmission-complete sets after the stop bit; interrupt when enabled.
// - transmission-complete clears by the same status-then-data sequence.
`timescale 1ns/100ps
module sct_top #(
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [DW-1:0] pwdata,
  output logic [DW-1:0]      prdata,
  output logic               pready,
  output logic               pslverr,
  // baud tick
  input  wire logic          baud_tick,
  // serial line and interrupt
  output logic               txd,
  output logic               irq
);
  import sct_pkg::*;

  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  acc_addr;
  logic        unmapped;

  sct_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .acc_addr (acc_addr),
    .unmapped (unmapped)
  );

  logic             wlen9_ff;
  logic             ninth_tx_bit_ff;
  logic             transmitter_enable_ff;
  logic             tx_empty_irq_enable_ff;
  logic             tx_complete_irq_enable_ff;
  logic             tx_buffer_empty_flag_ff;
  logic             tx_complete_flag_ff;
  logic             status_seen_ff;
  logic [8:0]       tx_holding_buffer_ff;
  logic             hold_full_ff;
  logic [SCT_IRQ_W-1:0] irq_st_ff;
  logic [SCT_IRQ_W-1:0] irq_msk_ff;
  sct_state_t       state_ff;
  logic [10:0]      shift_ff;
  logic [SCT_CNT_W-1:0] cnt_ff;
  logic             pre_req_ff;

  logic             data_wr;
  logic             status_acc;
  logic             frame_done;
  logic             load_now;
  logic             from_hold;
  logic [8:0]       load_word;
  logic [SCT_CNT_W-1:0] frame_bits;
  logic [SCT_CNT_W-1:0] pre_bits;
  logic             ten_rise;

  always_comb begin
    data_wr    = wr_stb && !unmapped && acc_addr == SCT_DATA_OFF;
    status_acc = psel && penable && !unmapped && acc_addr == SCT_STATUS_OFF;
    ten_rise   = wr_stb && acc_addr == SCT_CTRL2_OFF && pwdata[SCT_C2_TEN] &&
                 !transmitter_enable_ff;
    frame_bits = wlen9_ff ? SCT_CNT_W'(SCT_DATA9 + 2) : SCT_CNT_W'(SCT_DATA8 + 2);
    pre_bits   = wlen9_ff ? SCT_CNT_W'(SCT_PRE9) : SCT_CNT_W'(SCT_PRE8);
    frame_done = state_ff == SCT_FRAME && baud_tick && cnt_ff == SCT_CNT_W'(1);
    from_hold  = hold_full_ff && transmitter_enable_ff &&
                 (state_ff == SCT_IDLE || frame_done) && !pre_req_ff;
    load_now   = from_hold ||
                 (data_wr && state_ff == SCT_IDLE && !hold_full_ff &&
                  transmitter_enable_ff && !pre_req_ff);
    load_word  = from_hold ? tx_holding_buffer_ff :
                 {ninth_tx_bit_ff, pwdata[7:0]};
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wlen9_ff                  <= 1'b0;
      ninth_tx_bit_ff           <= 1'b0;
      transmitter_enable_ff     <= 1'b0;
      tx_empty_irq_enable_ff    <= 1'b0;
      tx_complete_irq_enable_ff <= 1'b0;
      irq_msk_ff                <= '0;
    end else if (wr_stb) begin
      unique case (acc_addr)
        SCT_CTRL1_OFF: begin
          wlen9_ff        <= pwdata[SCT_C1_WLEN];
          ninth_tx_bit_ff <= pwdata[SCT_C1_NINTH];
        end
        SCT_CTRL2_OFF: begin
          transmitter_enable_ff     <= pwdata[SCT_C2_TEN];
          tx_empty_irq_enable_ff    <= pwdata[SCT_C2_TXE_IE];
          tx_complete_irq_enable_ff <= pwdata[SCT_C2_TC_IE];
        end
        SCT_IRQMSK_OFF: irq_msk_ff <= pwdata[SCT_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // holding buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_buffer_ff <= '0;
      hold_full_ff         <= 1'b0;
    end else if (ten_rise) begin
      hold_full_ff <= 1'b0;
    // a write in the cycle the buffer drains into the shifter is kept, not lost
    end else if (data_wr && (!load_now || from_hold)) begin
      tx_holding_buffer_ff <= {ninth_tx_bit_ff, pwdata[7:0]};
      hold_full_ff         <= 1'b1;
    end else if (from_hold) begin
      hold_full_ff <= 1'b0;
    end
  end

  // status flags: a set wins over the clear sequence in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty_flag_ff <= 1'b1;
      tx_complete_flag_ff     <= 1'b1;
      status_seen_ff          <= 1'b0;
    end else begin
      if (status_acc)
        status_seen_ff <= 1'b1;
      else if (data_wr)
        status_seen_ff <= 1'b0;
      if (load_now)
        tx_buffer_empty_flag_ff <= 1'b1;
      else if (data_wr && status_seen_ff)
        tx_buffer_empty_flag_ff <= 1'b0;
      if (frame_done)
        tx_complete_flag_ff <= 1'b1;
      else if (data_wr && status_seen_ff)
        tx_complete_flag_ff <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_ff <= '0;
    end else begin
      for (int i = 0; i < SCT_IRQ_W; i++) begin
        if (wr_stb && acc_addr == SCT_IRQST_OFF && pwdata[i])
          irq_st_ff[i] <= 1'b0;
      end
      if (load_now && tx_empty_irq_enable_ff)
        irq_st_ff[SCT_IRQ_TXE] <= 1'b1;
      if (frame_done && tx_complete_irq_enable_ff)
        irq_st_ff[SCT_IRQ_TC] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_ff & irq_msk_ff);
  end

  // transmit sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= SCT_IDLE;
      shift_ff   <= '1;
      cnt_ff     <= '0;
      pre_req_ff <= 1'b0;
    end else begin
      if (ten_rise)
        pre_req_ff <= 1'b1;
      else if (state_ff == SCT_PREAMBLE && baud_tick && cnt_ff == SCT_CNT_W'(1))
        pre_req_ff <= 1'b0;
      unique case (state_ff)
        SCT_IDLE: begin
          shift_ff <= '1;
          if (pre_req_ff && transmitter_enable_ff) begin
            state_ff <= SCT_PREAMBLE;
            cnt_ff   <= pre_bits;
          end else if (load_now) begin
            state_ff <= SCT_FRAME;
            cnt_ff   <= frame_bits;
            shift_ff <= wlen9_ff ? {1'b1, load_word, 1'b0} : {2'b11, load_word[7:0], 1'b0};
          end
        end
        SCT_PREAMBLE: begin
          if (baud_tick) begin
            cnt_ff <= cnt_ff - SCT_CNT_W'(1);
            if (cnt_ff == SCT_CNT_W'(1))
              state_ff <= SCT_IDLE;
          end
        end
        SCT_FRAME: begin
          if (baud_tick) begin
            shift_ff <= {1'b1, shift_ff[10:1]};
            cnt_ff   <= cnt_ff - SCT_CNT_W'(1);
            if (frame_done) begin
              if (load_now) begin
                cnt_ff   <= frame_bits;
                shift_ff <= wlen9_ff ? {1'b1, load_word, 1'b0} :
                            {2'b11, load_word[7:0], 1'b0};
              end else begin
                state_ff <= SCT_IDLE;
              end
            end
          end
        end
        default: state_ff <= SCT_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      txd <= 1'b1;
    else
      txd <= (state_ff == SCT_FRAME) ? shift_ff[0] : 1'b1;
  end

  // apb read path, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (acc_addr)
          SCT_STATUS_OFF: begin
            prdata[SCT_ST_TXE]  <= tx_buffer_empty_flag_ff;
            prdata[SCT_ST_TC]   <= tx_complete_flag_ff;
            prdata[SCT_ST_BUSY] <= state_ff != SCT_IDLE;
          end
          SCT_CTRL1_OFF: begin
            prdata[SCT_C1_WLEN]  <= wlen9_ff;
            prdata[SCT_C1_NINTH] <= ninth_tx_bit_ff;
          end
          SCT_CTRL2_OFF: begin
            prdata[SCT_C2_TEN]    <= transmitter_enable_ff;
            prdata[SCT_C2_TXE_IE] <= tx_empty_irq_enable_ff;
            prdata[SCT_C2_TC_IE]  <= tx_complete_irq_enable_ff;
          end
          SCT_IRQST_OFF:  prdata[SCT_IRQ_W-1:0] <= irq_st_ff;
          SCT_IRQMSK_OFF: prdata[SCT_IRQ_W-1:0] <= irq_msk_ff;
          default: ;
        endcase
      end
    end
  end

  // assertions
  sequence frame_end_s;
    state_ff == SCT_FRAME && baud_tick && cnt_ff == SCT_CNT_W'(1);
  endsequence

  tc_after_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end_s |=> tx_complete_flag_ff)
    else $error("complete flag not set after stop bit");
  idle_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_ff) != SCT_FRAME |-> txd)
    else $error("line not high outside a frame");
  start_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_ff) == SCT_IDLE && state_ff == SCT_FRAME) |=> !txd)
    else $error("start bit not low");
  empty_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(tx_buffer_empty_flag_ff) |-> $past(data_wr) && $past(status_seen_ff))
    else $error("empty flag cleared without sequence");
  tc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(tx_complete_flag_ff) |-> $past(data_wr) && $past(status_seen_ff))
    else $error("complete flag cleared without sequence");
  idle_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (data_wr && state_ff == SCT_IDLE && !hold_full_ff && transmitter_enable_ff &&
     !pre_req_ff) |=> state_ff == SCT_FRAME && tx_buffer_empty_flag_ff)
    else $error("idle write did not start frame");
  busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (data_wr && state_ff == SCT_FRAME && !frame_done) |=> hold_full_ff)
    else $error("busy write not held");
  irq_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (load_now && tx_empty_irq_enable_ff) |=> irq_st_ff[SCT_IRQ_TXE])
    else $error("empty interrupt not raised");
  frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_ff) == SCT_IDLE && state_ff == SCT_FRAME) |->
      cnt_ff == (wlen9_ff ? SCT_CNT_W'(SCT_DATA9 + 2) : SCT_CNT_W'(SCT_DATA8 + 2)))
    else $error("frame length wrong");
  pre_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_ff) == SCT_IDLE && state_ff == SCT_PREAMBLE) |->
      cnt_ff == (wlen9_ff ? SCT_CNT_W'(SCT_PRE9) : SCT_CNT_W'(SCT_PRE8)))
    else $error("preamble length wrong");

  sequence first_tick_s;
    state_ff == SCT_FRAME && baud_tick && cnt_ff == frame_bits;
  endsequence

  lsb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_tick_s |=> ##1 txd == $past(shift_ff[1], 2))
    else $error("first data bit on the line is not bit zero");
  ninth_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (load_now && !from_hold && wlen9_ff) |=> shift_ff[SCT_DATA9] == $past(ninth_tx_bit_ff))
    else $error("ninth bit not taken from control register");
  hold_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    (data_wr && !load_now) |=>
      tx_holding_buffer_ff == {$past(ninth_tx_bit_ff), $past(pwdata[7:0])})
    else $error("data write not kept in holding buffer");
  empty_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    from_hold |=> tx_buffer_empty_flag_ff)
    else $error("empty flag not set when buffer moved to shifter");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |($past(irq_st_ff) & $past(irq_msk_ff)))
    else $error("interrupt output does not follow unmasked status");
endmodule

// ==== sim/sct_rx_model.sv ====
// remote receiver model: samples the serial line once per baud tick
// assumes the bench feeds the same baud tick to this model and to the transmitter
`timescale 1ns/100ps
module sct_rx_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // line side
  input  wire logic        baud_tick,
  input  wire logic        txd,
  input  wire logic        nine_mode,
  // decoded characters
  output logic [8:0]       rx_word,
  output logic [15:0]      n_words,
  output logic [7:0]       ones_seen,
  output logic             stop_bad
);
  logic [8:0] shift_ff;
  logic [4:0] bit_ff;
  logic [7:0] run_ff;
  // bit_ff: 0 hunting for a start bit, 1..n data bits, n+1 stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff  <= 9'h000;
      bit_ff    <= 5'h00;
      run_ff    <= 8'h00;
      rx_word   <= 9'h000;
      n_words   <= 16'h0000;
      ones_seen <= 8'h00;
      stop_bad  <= 1'b0;
    end else if (baud_tick) begin
      if (bit_ff == 5'h00) begin
        if (txd) begin
          run_ff <= run_ff + 8'h01;
        end else begin
          ones_seen <= run_ff;
          run_ff    <= 8'h00;
          shift_ff  <= 9'h000;
          bit_ff    <= 5'h01;
        end
      end else if (bit_ff <= (nine_mode ? 5'h09 : 5'h08)) begin
        shift_ff[bit_ff - 5'h01] <= txd;
        bit_ff                   <= bit_ff + 5'h01;
      end else begin
        stop_bad <= stop_bad | ~txd;
        rx_word  <= shift_ff;
        n_words  <= n_words + 16'h0001;
        bit_ff   <= 5'h00;
      end
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the serial character transmitter
// assumes the apb slave answers by itself; bench makes a baud tick every fourth clock
`timescale 1ns/100ps
module tb_top;
  import sct_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ticking, nine;
  logic        baud_tick = 1'b0;
  logic        pready, pslverr, txd, irq, last_err, stop_bad;
  logic [7:0]  paddr, ones_seen;
  logic [31:0] pwdata, prdata, last_rd;
  logic [8:0]  rx_word;
  logic [15:0] n_words;
  logic [1:0]  tick_cnt = 2'h0;
  int          failures, n_compared;

  sct_top #(.DW(32)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick(baud_tick), .txd(txd), .irq(irq));
  sct_rx_model rx (.pclk(pclk), .presetn(presetn), .baud_tick(baud_tick), .txd(txd),
    .nine_mode(nine), .rx_word(rx_word), .n_words(n_words), .ones_seen(ones_seen),
    .stop_bad(stop_bad));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ticks only while ticking, so idle ones before a preamble are not counted
  always @(posedge pclk) begin
    tick_cnt  <= ticking ? tick_cnt + 2'h1 : 2'h0;
    baud_tick <= ticking && (tick_cnt == 2'h3);
  end

  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        give_verdict;
      end
      @(posedge pclk);
    end
    // answer taken at the edge where pready is seen high, then released
    last_rd  = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_word;
    int n;
    logic [15:0] start;
    n = 0;
    start = n_words;
    while (n_words == start) begin
      @(posedge pclk);
      n++;
      if (n > 3000) begin
        failures++;
        give_verdict;
      end
    end
  endtask
  task do_reset;
    ticking <= 1'b0;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task test_reset_map;
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    check(last_rd, SCT_STATUS_RST);
    check(32'(txd), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(last_rd, 32'h0);
    check(32'(last_err), 32'h1);
  endtask
  // both word lengths; ninth bit changed after the write must not reach the line
  task test_frames;
    for (int m = 0; m < 2; m++) begin
      do_reset;
      nine <= m[0];
      apb(1'b1, SCT_CTRL1_OFF, (32'(m) << SCT_C1_WLEN) | (32'(m) << SCT_C1_NINTH));
      apb(1'b1, SCT_CTRL2_OFF, 32'h1 << SCT_C2_TEN);
      apb(1'b0, SCT_STATUS_OFF, 32'h0);
      apb(1'b1, SCT_DATA_OFF, 32'h4B);
      apb(1'b1, SCT_CTRL1_OFF, 32'(m) << SCT_C1_WLEN);
      ticking <= 1'b1;
      wait_word;
      check(32'(rx_word), {23'h0, m[0], 8'h4B});
      check(32'(ones_seen), m ? SCT_PRE9 : SCT_PRE8);
      check(32'(stop_bad), 32'h0);
    end
  endtask
  task test_buffer;
    apb(1'b1, SCT_CTRL2_OFF, (32'h1 << SCT_C2_TEN) | 32'hC0);
    apb(1'b1, SCT_IRQMSK_OFF, 32'h3);
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    apb(1'b1, SCT_DATA_OFF, 32'h3C);
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    check(last_rd & 32'hC1, 32'h81);
    apb(1'b1, SCT_DATA_OFF, 32'hC3);
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    check(last_rd & 32'hC0, 32'h0);
    wait_word;
    check(32'(rx_word), 32'h3C);
    wait_word;
    check(32'(rx_word), 32'hC3);
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    check(last_rd & 32'hC1, 32'hC0);
    apb(1'b0, SCT_IRQST_OFF, 32'h0);
    check(last_rd, 32'h3);
    check(32'(irq), 32'h1);
    // second write has no status access before it, so empty must stay set
    apb(1'b1, SCT_DATA_OFF, 32'h96);
    apb(1'b1, SCT_DATA_OFF, 32'h69);
    apb(1'b0, SCT_STATUS_OFF, 32'h0);
    check(last_rd & 32'hC0, 32'h80);
    wait_word;
    check(32'(rx_word), 32'h96);
    wait_word;
    check(32'(rx_word), 32'h69);
    check(32'(txd), 32'h1);
  endtask
  task test_irq;
    apb(1'b1, SCT_IRQMSK_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    apb(1'b1, SCT_IRQMSK_OFF, 32'h3);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b1, SCT_IRQST_OFF, 32'h3);
    apb(1'b0, SCT_IRQST_OFF, 32'h0);
    check(last_rd, 32'h0);
    check(32'(irq), 32'h0);
  endtask

  initial begin
    #400000;
    failures++;
    give_verdict;
  end
  initial begin
    {psel, penable, pwrite, ticking, nine, presetn} = 6'h00;
    {paddr, pwdata} = 40'h0;
    failures = 0;
    n_compared = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_map;
    test_frames;
    test_buffer;
    test_irq;
    give_verdict;
  end
endmodule
